/* File: bench/sft_remote.sv */
// remote station model: transmit clock source and frame receiver
`timescale 1ns/100ps
module sft_remote (
  // serial link
  input wire logic txd_i,
  output logic txc_o
);
  logic [7:0] hist_q = 8'h00;
  int ones = 0;
  int longest = 0;
  int flag_cnt = 0;
  int frame_cnt = 0;
  int abort_cnt = 0;
  bit raw[$];
  bit last[$];

  // ------------------------------------------------------------
  // free running clock, line sampled at the falling edge
  // ------------------------------------------------------------
  initial txc_o = 1'b1;
  always #80 txc_o = ~txc_o;

  // ------------------------------------------------------------
  // flag hunt, zero deletion, abort detection
  // ------------------------------------------------------------
  always @(negedge txc_o) begin
    hist_q = {txd_i, hist_q[7:1]};
    if (txd_i === 1'b1) begin
      ones++;
      raw.push_back(1'b1);
      if (ones > longest) longest = ones;
      if (ones == 7) abort_cnt++;
      if (ones >= 7) raw.delete();
    end else begin
      if (hist_q == 8'h7E) begin
        flag_cnt++;
        // flag bits already queued are not frame content
        repeat (7) if (raw.size() > 0) void'(raw.pop_back());
        if (raw.size() > 0) begin
          last = raw;
          frame_cnt++;
        end
        raw.delete();
      end else if (ones != 5) begin // stuffed zeros dropped
        raw.push_back(1'b0);
      end
      ones = 0;
    end
  end
endmodule // sft_remote

/* File: bench/tb_top.sv */
// testbench: register port stimulus and line checks of the frame transmitter
`timescale 1ns/100ps
module tb_top
  import sft_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic txc;
  logic txd_o;
  logic rts_n_o;
  logic dtr_n_o;
  logic int_o;
  logic wait_ready_n_o;
  logic cts_n_i = 1'b0;
  logic [7:0] st;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 clock_i = ~clock_i;

  sft_transmitter sft_transmitter_i (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txc_i(txc), .cts_n_i(cts_n_i),
    .txd_o(txd_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .int_o(int_o),
    .wait_ready_n_o(wait_ready_n_o)
  );

  sft_remote sft_remote_i (
    .txd_i(txd_o),
    .txc_o(txc)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task final_report;
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic bits(input int n);
    repeat (n) @(negedge txc);
    #1;
  endtask

  task automatic poll(input logic [7:0] mask, input logic [7:0] val);
    int n;
    n = 0;
    reg_rd(OFF_STATUS, st);
    while ((st & mask) !== val && n < 400) begin
      reg_rd(OFF_STATUS, st);
      n++;
    end
    check("status poll", val, st & mask);
  endtask

  // returns well clear of a character boundary
  task automatic sync_flag;
    int fc;
    int n;
    fc = sft_remote_i.flag_cnt;
    n = 0;
    while (sft_remote_i.flag_cnt == fc && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    cyc(10);
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check("idle line", 1, txd_o);
    check("int idle", 0, int_o);
    check("wait idle", 1, wait_ready_n_o);
    reg_rd(OFF_STATUS, st);
    check("reset status", 8'h10, st & 8'h1D);
    reg_rd(3'h7, st);
    check("unmapped read", 8'h00, st);
  endtask

  task automatic t_break;
    reg_wr(OFF_PMS, 8'h20);
    reg_wr(OFF_RXC, 8'h00);
    reg_wr(OFF_TCTL, 8'h92);
    cyc(3);
    check("break line", 0, txd_o);
    check("rts", 0, rts_n_o);
    check("dtr", 0, dtr_n_o);
    reg_wr(OFF_TCTL, 8'h82);
    cyc(3);
    check("mark line", 1, txd_o);
  endtask

  task automatic t_flags;
    int fc;
    reg_wr(OFF_RXC, 8'h20);
    cts_n_i <= 1'b1;
    reg_wr(OFF_ICTL, 8'h03);
    reg_wr(OFF_TCTL, 8'hEB);
    bits(16);
    check("cts hold", 1, sft_remote_i.ones >= 16);
    @(posedge clock_i);
    cts_n_i <= 1'b0;
    fc = sft_remote_i.flag_cnt;
    bits(48);
    check("flag run", 1, (sft_remote_i.flag_cnt - fc) >= 5);
    check("no empty int", 0, int_o);
  endtask

  task automatic t_frame(input logic [1:0] code, input int nbits, input bit abort_it);
    logic [7:0] data [3];
    logic [15:0] crc;
    bit exp[$];
    int fc;
    int ac;
    int bad;
    int n;
    data = '{8'hFF, 8'h7E, 8'h5B};
    crc = CRC_PRESET;
    fc = sft_remote_i.frame_cnt;
    ac = sft_remote_i.abort_cnt;
    bad = 0;
    n = 0;
    reg_wr(OFF_TCTL, {1'b1, code, 5'h0B});
    reg_wr(OFF_CMD, 8'h80);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) poll(8'h01, 8'h00);
      reg_wr(OFF_TXDATA, data[i]);
      if (i == 0) reg_wr(OFF_CMD, 8'hC0);
      for (int j = 0; j < nbits; j++) begin
        exp.push_back(data[i][j]);
        crc = crc_step(crc, data[i][j]);
      end
    end
    for (int j = 0; j < 16; j++) exp.push_back(~crc[j]);
    poll(8'h1A, 8'h18);
    if (abort_it) begin
      reg_wr(OFF_TXDATA, 8'h55);
      reg_rd(OFF_STATUS, st);
      check("crc kept", 8'h10, st & 8'h12);
      sft_remote_i.longest = 0;
      n = sft_remote_i.flag_cnt;
      reg_wr(OFF_CMD, 8'h08);
      bits(40);
      check("abort run", 1, sft_remote_i.longest >= 8 && sft_remote_i.longest < 14);
      check("flags resume", 1, sft_remote_i.flag_cnt - n >= 2);
      check("abort seen", ac + 1, sft_remote_i.abort_cnt);
      check("no frame", fc, sft_remote_i.frame_cnt);
      reg_rd(OFF_STATUS, st);
      check("buffer dropped", 8'h00, st & 8'h01);
    end else begin
      reg_wr(OFF_CMD, 8'h28);
      while (sft_remote_i.frame_cnt == fc && n < 3000) begin
        @(posedge clock_i);
        n++;
      end
      check("frames", fc + 1, sft_remote_i.frame_cnt);
      check("frame length", exp.size(), sft_remote_i.last.size());
      foreach (exp[j]) if (j < sft_remote_i.last.size() && sft_remote_i.last[j] !== exp[j]) bad++;
      check("frame bits", 0, bad);
      reg_rd(OFF_STATUS, st);
      check("crc done", 8'h16, st & 8'h16);
      check("int raised", 1, int_o);
    end
    reg_wr(OFF_CMD, 8'h28);
    reg_wr(OFF_CMD, 8'h10);
    bits(20);
    check("int cleared", 0, int_o);
  endtask

  task automatic t_dma;
    sync_flag();
    reg_wr(OFF_ICTL, 8'h0B);
    reg_wr(OFF_TXDATA, 8'hA5);
    cyc(2);
    check("wait full", 0, wait_ready_n_o);
    reg_wr(OFF_CMD, 8'h08);
    cyc(3);
    check("wait after abort", 1, wait_ready_n_o);
    reg_wr(OFF_ICTL, 8'h0F);
    bits(30);
    check("ready empty", 0, wait_ready_n_o);
    reg_wr(OFF_ICTL, 8'h03);
    reg_wr(OFF_CMD, 8'h28);
  endtask

  task automatic t_disable;
    int fc;
    sync_flag();
    bits(3);
    fc = sft_remote_i.flag_cnt;
    reg_wr(OFF_TCTL, 8'h80);
    bits(30);
    check("flag finished", fc + 1, sft_remote_i.flag_cnt);
    check("marking", 1, sft_remote_i.ones >= 20);
    check("rts off", 1, rts_n_o);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_break();
    t_flags();
    t_frame(LEN_5, 5, 1'b0);
    t_frame(LEN_6, 6, 1'b0);
    t_frame(LEN_7, 7, 1'b0);
    t_frame(2'h3, 8, 1'b0);
    t_frame(2'h3, 8, 1'b1);
    t_dma();
    t_disable();
    final_report();
  end
endmodule // tb_top

/* File: hdl/sft_pkg.sv */
// package: constants, types and register map of the sdlc frame transmitter
package sft_pkg;

  // ----------------------------------------------------------------
  // register offsets (3-bit register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_CMD = 3'h0;
  localparam logic [2:0] OFF_RXC = 3'h1;
  localparam logic [2:0] OFF_PMS = 3'h2;
  localparam logic [2:0] OFF_TCTL = 3'h3;
  localparam logic [2:0] OFF_TXDATA = 3'h4;
  localparam logic [2:0] OFF_STATUS = 3'h5;
  localparam logic [2:0] OFF_ICTL = 3'h6;

  // ----------------------------------------------------------------
  // reset values and crc polynomial
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_CLEAR = 16'h0000;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_LSB = 3;
  localparam int CMD_MSB = 5;
  localparam int CRCCMD_LSB = 6;
  localparam int CRCCMD_MSB = 7;
  localparam int RXC_AUTO_EN = 5;
  localparam int PMS_SYNC_LSB = 4;
  localparam int PMS_SYNC_MSB = 5;
  localparam int TCTL_CRC_EN = 0;
  localparam int TCTL_RTS = 1;
  localparam int TCTL_CRC_SEL = 2;
  localparam int TCTL_TX_EN = 3;
  localparam int TCTL_BREAK = 4;
  localparam int TCTL_LEN_LSB = 5;
  localparam int TCTL_LEN_MSB = 6;
  localparam int TCTL_DTR = 7;
  localparam int ICTL_EXT_EN = 0;
  localparam int ICTL_TX_EN = 1;
  localparam int ICTL_WR_READY = 2;
  localparam int ICTL_WR_EN = 3;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_SEND_ABORT = 3'h1;
  localparam logic [2:0] CMD_RST_EXT = 3'h2;
  localparam logic [2:0] CMD_CLR_TX_INT = 3'h5;
  localparam logic [1:0] CRCCMD_RST_TXCRC = 2'h2;
  localparam logic [1:0] CRCCMD_RST_EOM = 2'h3;
  localparam logic [1:0] PMS_SDLC = 2'h2;
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [1:0] LEN_6 = 2'h2;
  localparam logic [1:0] LEN_7 = 2'h1;
  localparam logic [2:0] LAST_5 = 3'h4;
  localparam logic [2:0] LAST_6 = 3'h5;
  localparam logic [2:0] LAST_7 = 3'h6;
  localparam logic [2:0] LAST_8 = 3'h7;
  localparam logic [7:0] FLAG_CHAR = 8'h7E;
  localparam logic [7:0] ABORT_CHAR = 8'hFF;
  localparam logic [2:0] STUFF_RUN = 3'h5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FLAG = 3'h1,
    ST_DATA = 3'h3,
    ST_CRC = 3'h2,
    ST_ABORT = 3'h6
  } sft_state_t;

  typedef struct packed {
    logic abort_busy;
    logic cts;
    logic sending;
    logic underrun_end_of_message_latch;
    logic ext_ip;
    logic tx_ip;
    logic tbe;
    logic buf_full;
  } sft_status_t;

endpackage

/* File: hdl/sft_transmitter.sv */
// sdlc frame transmitter: register port, flag/data/crc/abort serialiser
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps

// Contract
// - crc reset command presets generator to ones in sdlc mode with sdlc crc selected, else clears it to zeros
// - line marks after reset and when disabled
// - break drives the line spacing
// - enabled idle transmitter sends continuous flags
// - abort sends eight ones then flags
// - abort discards shifting and buffered characters
// - zero after five ones, data/crc only
// - transmit interrupt on buffer full to empty
// - clear command ends pending transmit interrupt
// - no empty interrupt before first write
// - wait while full, ready while empty
// - empty shifter with empty buffer is underrun
// - underrun with latch clear sends crc, flags
// - latch set after reset; empty sends flags
// - command clears latch; crc start sets it
// - crc shows latch set, buffer not empty
// - underrun latch set raises external interrupt
// - character written during crc waits behind it
// - host aborts within 22 to 30 clocks
// - length codes 00=5 10=6 01=7 11=8
// - crc covers frame bits, sent complemented
// - characters go out lsb first
// - disable finishes character, then marks
module sft_transmitter
  import sft_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // serial link
  input wire logic txc_i,
  input wire logic cts_n_i,
  output logic txd_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  // cpu and dma side
  output logic int_o,
  output logic wait_ready_n_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] rxc_q, pms_q, tctl_q, ictl_q, buf_q, sh_q, rdata_q;
  logic buf_full_q, crc_hi_q, eom_q, tx_ip_q, ext_ip_q, abort_req_q;
  logic txd_q, int_q, wr_n_q, rts_n_q, dtr_n_q;
  logic txc_s1_q, txc_s2_q, txc_s3_q, cts_s1_q, cts_s2_q;
  logic [2:0] rem_q, ones_q;
  logic [15:0] crc_q;
  sft_state_t state_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_cmd = wr_i && (addr_i == OFF_CMD);
  wire wr_data = wr_i && (addr_i == OFF_TXDATA);
  wire [2:0] cmd = wdata_i[CMD_MSB:CMD_LSB];
  wire [1:0] crc_cmd = wdata_i[CRCCMD_MSB:CRCCMD_LSB];
  wire cmd_abort = wr_cmd && (cmd == CMD_SEND_ABORT);
  wire cmd_rst_ext = wr_cmd && (cmd == CMD_RST_EXT);
  wire cmd_clr_txip = wr_cmd && (cmd == CMD_CLR_TX_INT);
  wire cmd_rst_crc = wr_cmd && (crc_cmd == CRCCMD_RST_TXCRC);
  wire cmd_rst_eom = wr_cmd && (crc_cmd == CRCCMD_RST_EOM);
  wire sdlc_mode = (pms_q[PMS_SYNC_MSB:PMS_SYNC_LSB] == PMS_SDLC);
  wire sdlc_crc = !tctl_q[TCTL_CRC_SEL];
  wire brk = tctl_q[TCTL_BREAK];
  wire cts_ok = !rxc_q[RXC_AUTO_EN] || !cts_s2_q;
  wire tx_enable = tctl_q[TCTL_TX_EN] && sdlc_mode && cts_ok;
  // data changes on the falling edge of the link clock
  wire tick = txc_s3_q && !txc_s2_q;
  wire in_frame = (state_q == ST_DATA) || (state_q == ST_CRC);
  wire stuff_now = in_frame && (ones_q == STUFF_RUN);
  // abort waits out a flag's closing zero or a running abort: at most 13 ones
  wire abort_hold = ((state_q == ST_FLAG) && (rem_q == 3'h1)) || (state_q == ST_ABORT);
  wire abort_go = tick && abort_req_q && !abort_hold;
  wire at_bound = (rem_q == 3'h0);
  wire tbe = !buf_full_q && (state_q != ST_CRC);

  // length code to last bit index
  function automatic logic [2:0] last_bit(input logic [1:0] code);
    case (code)
      LEN_5: last_bit = LAST_5;
      LEN_6: last_bit = LAST_6;
      LEN_7: last_bit = LAST_7;
      default: last_bit = LAST_8;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next character selection at a character boundary
  // ----------------------------------------------------------------
  sft_state_t nx_state;
  logic [7:0] nx_char;
  logic [2:0] nx_last;
  logic take_buf, crc_start, crc_done;

  always_comb begin
    nx_state = state_q;
    nx_char = FLAG_CHAR;
    nx_last = LAST_8;
    take_buf = 1'b0;
    crc_start = 1'b0;
    crc_done = 1'b0;
    if (!tx_enable) begin
      nx_state = ST_IDLE;
      nx_char = ABORT_CHAR;
      nx_last = 3'h0;
    end else begin
      case (state_q)
        ST_CRC: begin
          if (crc_hi_q) begin
            nx_char = ~crc_q[15:8];
          end else begin
            nx_state = ST_FLAG;
            crc_done = 1'b1;
          end
        end
        ST_DATA: begin
          if (buf_full_q) begin
            nx_char = buf_q;
            nx_last = last_bit(tctl_q[TCTL_LEN_MSB:TCTL_LEN_LSB]);
            take_buf = 1'b1;
          end else if (!eom_q) begin
            nx_state = ST_CRC;
            nx_char = ~crc_q[7:0];
            crc_start = 1'b1;
          end else begin
            nx_state = ST_FLAG;
          end
        end
        default: begin
          if (buf_full_q && (state_q != ST_IDLE)) begin
            nx_state = ST_DATA;
            nx_char = buf_q;
            nx_last = last_bit(tctl_q[TCTL_LEN_MSB:TCTL_LEN_LSB]);
            take_buf = 1'b1;
          end else begin
            nx_state = ST_FLAG;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit selection for this tick
  // ----------------------------------------------------------------
  wire load_now = tick && !abort_go && !stuff_now && at_bound;
  wire crc_starts = load_now && crc_start;
  wire buf_taken = load_now && take_buf;
  wire crc_ends = load_now && crc_done;
  sft_state_t cur_state;
  logic out_bit;
  logic [2:0] ones_d;
  logic [15:0] crc_step;

  always_comb begin
    cur_state = state_q;
    out_bit = sh_q[0];
    if (abort_go) begin
      cur_state = ST_ABORT;
      out_bit = 1'b1;
    end else if (stuff_now) begin
      out_bit = 1'b0;
    end else if (at_bound) begin
      cur_state = nx_state;
      out_bit = (nx_state == ST_IDLE) ? 1'b1 : nx_char[0];
    end
  end

  always_comb begin
    ones_d = 3'h0;
    if (!stuff_now && !abort_go && out_bit &&
        ((cur_state == ST_DATA) || (cur_state == ST_CRC))) begin
      ones_d = ones_q + 3'h1;
    end
  end

  wire crc_acc = tick && !abort_go && !stuff_now && (cur_state == ST_DATA) &&
                 tctl_q[TCTL_CRC_EN];
  assign crc_step = (crc_q[0] ^ out_bit) ? ((crc_q >> 1) ^ CRC_POLY_REFL) : (crc_q >> 1);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rxc_q <= RST_REG;
      pms_q <= RST_REG;
      tctl_q <= RST_REG;
      ictl_q <= RST_REG;
      buf_q <= RST_REG;
    end else if (wr_i) begin
      if (addr_i == OFF_RXC) rxc_q <= wdata_i;
      if (addr_i == OFF_PMS) pms_q <= wdata_i;
      if (addr_i == OFF_TCTL) tctl_q <= wdata_i;
      if (addr_i == OFF_ICTL) ictl_q <= wdata_i;
      if (addr_i == OFF_TXDATA) buf_q <= wdata_i;
    end
  end

  sft_status_t status;
  assign status = '{abort_busy: abort_req_q || (state_q == ST_ABORT), cts: !cts_s2_q,
                    sending: state_q != ST_IDLE, underrun_end_of_message_latch: eom_q, ext_ip: ext_ip_q,
                    tx_ip: tx_ip_q, tbe: tbe, buf_full: buf_full_q};
  wire [7:0] rd_mux = (addr_i == OFF_STATUS) ? status :
                      (addr_i == OFF_RXC) ? rxc_q :
                      (addr_i == OFF_PMS) ? pms_q :
                      (addr_i == OFF_TCTL) ? tctl_q :
                      (addr_i == OFF_ICTL) ? ictl_q : 8'h00;

  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_q <= 8'h00;
    else rdata_q <= rd_i ? rd_mux : 8'h00;
  end

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      txc_s1_q <= 1'b0;
      txc_s2_q <= 1'b0;
      txc_s3_q <= 1'b0;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
    end else begin
      txc_s1_q <= txc_i;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
      cts_s1_q <= cts_n_i;
      cts_s2_q <= cts_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // buffer, latches and pending flags (set wins over clear)
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      buf_full_q <= 1'b0;
      abort_req_q <= 1'b0;
      eom_q <= 1'b1;
      tx_ip_q <= 1'b0;
      ext_ip_q <= 1'b0;
    end else begin
      if (wr_data) buf_full_q <= 1'b1;
      else if (cmd_abort || buf_taken) buf_full_q <= 1'b0;
      if (cmd_abort) abort_req_q <= 1'b1;
      else if (abort_go) abort_req_q <= 1'b0;
      if (crc_starts) eom_q <= 1'b1;
      else if (cmd_rst_eom) eom_q <= 1'b0;
      if ((buf_taken || crc_ends) && ictl_q[ICTL_TX_EN]) tx_ip_q <= 1'b1;
      else if (cmd_clr_txip) tx_ip_q <= 1'b0;
      if (crc_starts && ictl_q[ICTL_EXT_EN]) ext_ip_q <= 1'b1;
      else if (cmd_rst_ext) ext_ip_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // serialiser
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      sh_q <= 8'h00;
      rem_q <= 3'h0;
      ones_q <= 3'h0;
      crc_hi_q <= 1'b0;
    end else if (tick) begin
      ones_q <= ones_d;
      if (abort_go) begin
        state_q <= ST_ABORT;
        sh_q <= ABORT_CHAR >> 1;
        rem_q <= LAST_8;
        crc_hi_q <= 1'b0;
      end else if (!stuff_now) begin
        if (at_bound) begin
          state_q <= nx_state;
          sh_q <= nx_char >> 1;
          rem_q <= nx_last;
          if (crc_start) crc_hi_q <= 1'b1;
          else if (state_q == ST_CRC) crc_hi_q <= 1'b0;
        end else begin
          sh_q <= sh_q >> 1;
          rem_q <= rem_q - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) crc_q <= CRC_PRESET;
    else if (cmd_rst_crc) crc_q <= (sdlc_mode && sdlc_crc) ? CRC_PRESET : CRC_CLEAR;
    else if (crc_acc) crc_q <= crc_step;
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      txd_q <= 1'b1;
      int_q <= 1'b0;
      wr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end else begin
      if (brk) txd_q <= 1'b0;
      else if (tick) txd_q <= out_bit;
      else if (state_q == ST_IDLE) txd_q <= 1'b1;
      int_q <= tx_ip_q || ext_ip_q;
      if (!ictl_q[ICTL_WR_EN]) wr_n_q <= 1'b1;
      else if (ictl_q[ICTL_WR_READY]) wr_n_q <= !tbe;
      else wr_n_q <= !buf_full_q;
      rts_n_q <= !tctl_q[TCTL_RTS];
      dtr_n_q <= !tctl_q[TCTL_DTR];
    end
  end

  assign rdata_o = rdata_q;
  assign txd_o = txd_q;
  assign int_o = int_q;
  assign wait_ready_n_o = wr_n_q;
  assign rts_n_o = rts_n_q;
  assign dtr_n_o = dtr_n_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  idle_mark_a: assert property ((state_q == ST_IDLE) && !tx_enable && !brk |=> txd_o)
    else $error("line not marking while idle");
  break_space_a: assert property (brk |=> !txd_o)
    else $error("break not spacing");
  crc_preset_a: assert property (cmd_rst_crc && sdlc_mode && sdlc_crc |=> crc_q == CRC_PRESET)
    else $error("crc not preset");
  abort_drop_a: assert property (cmd_abort && !wr_data |=> !buf_full_q ##0 abort_req_q)
    else $error("abort kept buffer");
  abort_run_a: assert property (abort_go |=> (state_q == ST_ABORT) && (rem_q == 3'h7))
    else $error("abort run not started");
  stuff_zero_a: assert property (tick && stuff_now && !abort_go && !brk |=> !txd_o)
    else $error("no zero after five ones");
  ones_bound_a: assert property (ones_q <= 3'h5)
    else $error("ones run too long");
  eom_set_a: assert property (crc_starts |=> eom_q && (state_q == ST_CRC) && !tbe)
    else $error("crc start without latch");
  ext_int_a: assert property (crc_starts && ictl_q[ICTL_EXT_EN] |=> ext_ip_q ##1 int_o)
    else $error("no external interrupt");
  txip_clear_a: assert property (cmd_clr_txip && !buf_taken && !crc_ends |=> !tx_ip_q)
    else $error("transmit pending not cleared");
  ready_dma_a: assert property (ictl_q[ICTL_WR_EN] && ictl_q[ICTL_WR_READY] && tbe
                                |=> !wait_ready_n_o)
    else $error("ready missing while empty");

  abort_seen_c: cover property (abort_go ##[1:200] (state_q == ST_FLAG));
  crc_close_c: cover property (crc_starts ##[1:400] crc_ends);
  data_load_c: cover property (buf_taken && (state_q == ST_FLAG));
  queued_c: cover property ((state_q == ST_CRC) && wr_data);

endmodule // sft_transmitter
